// ### hdl/afs_regs.svh
// Constants for the amplifier fault status decoder
`ifndef AFS_REGS_SVH
`define AFS_REGS_SVH
// Shutdown pulse length, clock period, counter and synchroniser reset constants
`define AFS_SD_PULSE_NS   1000
`define AFS_CLK_NS        25
`define AFS_SD_PULSE_CYC  ((`AFS_SD_PULSE_NS + `AFS_CLK_NS - 1) / `AFS_CLK_NS)
`define AFS_CNT_W         8
`define AFS_CNT_ZERO      8'h00
`define AFS_CNT_ONE       8'h01
`define AFS_SYNC_RST      4'h0
`endif

// ### hdl/afs_pkg.sv
// Types for the amplifier fault status decoder
package afs_pkg;
	// Raw fault conditions from the power stage
	typedef struct packed {
		logic overtemp_err;
		logic overcurrent_err;
		logic undervoltage;
		logic overtemp_warn;
	} afs_cond_t;
	// Open-drain pin pair: output value and enable
	typedef struct packed {
		logic overtemp_warning_n_o;
		logic overtemp_warning_n_oe;
		logic shutdown_fault_n_o;
		logic shutdown_fault_n_oe;
	} afs_pins_t;
	// Recovery sequencer states
	typedef enum logic [1:0] {
		AFS_RUN   = 2'b00,
		AFS_SHUT  = 2'b01,
		AFS_WAIT  = 2'b10
	} afs_state_t;
endpackage

// ### hdl/afs_sync.sv
// Three-stage synchroniser with agreement filter
`timescale 1ns/10ps
`default_nettype none
`include "afs_regs.svh"
module afs_sync (
	// Clock and reset
	input  wire logic       clk_i,
	input  wire logic       resetn_i,
	// Data
	input  wire logic [3:0] async_i,
	output logic      [3:0] sync_o
);
	logic [3:0] s1_ff;
	logic [3:0] s2_ff;
	logic [3:0] s3_ff;
	// Shift chain
	always_ff @(posedge clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			s1_ff <= `AFS_SYNC_RST;
			s2_ff <= `AFS_SYNC_RST;
			s3_ff <= `AFS_SYNC_RST;
		end else begin
			s1_ff <= async_i;
			s2_ff <= s1_ff;
			s3_ff <= s2_ff;
		end
	end
	// Accept a change once stages two and three agree
	always_ff @(posedge clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			sync_o <= `AFS_SYNC_RST;
		end else begin
			for (int i = 0; i < 4; i++) begin
				if (s2_ff[i] == s3_ff[i]) begin
					sync_o[i] <= s3_ff[i];
				end
			end
		end
	end
endmodule
`default_nettype wire

// ### hdl/afs_top.sv
// Amplifier fault status decoder driving open-drain status lines
`timescale 1ns/10ps
`default_nettype none
`include "afs_regs.svh"
module afs_top (
	// Clock and reset
	input  wire logic                clk_i,
	input  wire logic                resetn_i,
	// Fault conditions from the power stage
	input  wire afs_pkg::afs_cond_t  cond_i,
	// Status pins
	output var afs_pkg::afs_pins_t   pins_o,
	// Stage enable back to the power stage
	output logic                     stage_run_o
);
	import afs_pkg::*;

	afs_cond_t              cond_s;
	afs_state_t             state_ff;
	afs_state_t             nxt_state;
	logic [`AFS_CNT_W-1:0]  cnt_ff;
	logic                   warn_n_ff;
	logic                   sd_n_ff;
	logic                   hard_err;
	logic                   sd_cond;

	// Bring the asynchronous conditions into the clock domain
	afs_sync u_sync (
		.clk_i    (clk_i),
		.resetn_i (resetn_i),
		.async_i  (cond_i),
		.sync_o   (cond_s)
	);

	// Error classes
	assign hard_err = cond_s.overtemp_err | cond_s.overcurrent_err;
	assign sd_cond  = hard_err | cond_s.undervoltage;

	// Recovery sequencer: shut, pulse, wait for clear, restart
	always_comb begin
		nxt_state = state_ff;
		case (state_ff)
			AFS_RUN: begin
				if (sd_cond) begin
					nxt_state = AFS_SHUT;
				end
			end
			AFS_SHUT: begin
				if (cnt_ff == `AFS_CNT_ONE) begin
					nxt_state = AFS_WAIT;
				end
			end
			AFS_WAIT: begin
				if (!sd_cond) begin
					nxt_state = AFS_RUN;
				end
			end
			default: begin
				nxt_state = AFS_RUN;
			end
		endcase
	end

	// State register
	always_ff @(posedge clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			state_ff <= AFS_RUN;
		end else begin
			state_ff <= nxt_state;
		end
	end

	// Shutdown pulse length counter
	always_ff @(posedge clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			cnt_ff <= `AFS_CNT_ZERO;
		end else if (state_ff == AFS_RUN && sd_cond) begin
			cnt_ff <= `AFS_CNT_W'(`AFS_SD_PULSE_CYC);
		end else if (cnt_ff != `AFS_CNT_ZERO) begin
			cnt_ff <= cnt_ff - `AFS_CNT_ONE;
		end
	end

	// Shutdown line: low only for the brief pulse
	always_ff @(posedge clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			sd_n_ff <= 1'b1;
		end else begin
			sd_n_ff <= !(nxt_state == AFS_SHUT);
		end
	end

	// Warning line: follows warning or overtemp error directly
	always_ff @(posedge clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			warn_n_ff <= 1'b1;
		end else begin
			warn_n_ff <= !(cond_s.overtemp_warn
				| cond_s.overtemp_err);
		end
	end

	// Open-drain drive: enable only while pulling low
	always_comb begin
		pins_o.overtemp_warning_n_o  = 1'b0;
		pins_o.overtemp_warning_n_oe = !warn_n_ff;
		pins_o.shutdown_fault_n_o    = 1'b0;
		pins_o.shutdown_fault_n_oe   = !sd_n_ff;
	end
	assign stage_run_o = (state_ff == AFS_RUN);

	// Checks
	property p_sd_pulse_len;
		@(posedge clk_i) disable iff (!resetn_i)
		$fell(sd_n_ff) |-> !sd_n_ff [*3] ##1 1'b1;
	endproperty
	a_sd_pulse_len: assert property (p_sd_pulse_len)
		else $error("shutdown pulse too short");

	property p_sd_released;
		@(posedge clk_i) disable iff (!resetn_i)
		$fell(sd_n_ff) |-> ##[1:45] sd_n_ff;
	endproperty
	a_sd_released: assert property (p_sd_released)
		else $error("shutdown not released");

	property p_err_fires;
		@(posedge clk_i) disable iff (!resetn_i)
		(state_ff == AFS_RUN && sd_cond) |=> !sd_n_ff;
	endproperty
	a_err_fires: assert property (p_err_fires)
		else $error("error did not pull shutdown");

	property p_warn_follow;
		@(posedge clk_i) disable iff (!resetn_i)
		cond_s.overtemp_warn |=> !warn_n_ff;
	endproperty
	a_warn_follow: assert property (p_warn_follow)
		else $error("warning not asserted");

	property p_uv_keeps_warn;
		@(posedge clk_i) disable iff (!resetn_i)
		((cond_s.undervoltage || cond_s.overcurrent_err)
			&& !cond_s.overtemp_warn && !cond_s.overtemp_err)
			|=> warn_n_ff;
	endproperty
	a_uv_keeps_warn: assert property (p_uv_keeps_warn)
		else $error("warning driven on undervoltage");

	property p_normal_idle;
		@(posedge clk_i) disable iff (!resetn_i)
		(!sd_cond && !cond_s.overtemp_warn && state_ff != AFS_SHUT)
			|=> (warn_n_ff && sd_n_ff);
	endproperty
	a_normal_idle: assert property (p_normal_idle)
		else $error("warning low in normal operation");

	property p_warn_only;
		@(posedge clk_i) disable iff (!resetn_i)
		(state_ff == AFS_RUN && !sd_cond && cond_s.overtemp_warn)
			|=> (!warn_n_ff && sd_n_ff);
	endproperty
	a_warn_only: assert property (p_warn_only)
		else $error("warning-only code wrong");

	property p_od_low;
		@(posedge clk_i) disable iff (!resetn_i)
		1'b1 |-> (!pins_o.overtemp_warning_n_o
			&& !pins_o.shutdown_fault_n_o
			&& (pins_o.shutdown_fault_n_oe == (state_ff == AFS_SHUT)));
	endproperty
	a_od_low: assert property (p_od_low)
		else $error("open-drain drives high");

	c_sd_pulse:  cover property (@(posedge clk_i) $fell(sd_n_ff));
	c_warn:      cover property (@(posedge clk_i) $fell(warn_n_ff));
	c_both:      cover property (@(posedge clk_i) !warn_n_ff && !sd_n_ff);
	c_refused:   cover property (@(posedge clk_i)
		state_ff == AFS_WAIT && sd_cond);

	// Length of the current shutdown pulse, for the checks
	logic [`AFS_CNT_W-1:0]  sd_low_cnt_ff;
	always_ff @(posedge clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			sd_low_cnt_ff <= `AFS_CNT_ZERO;
		end else if (!sd_n_ff) begin
			sd_low_cnt_ff <= sd_low_cnt_ff + `AFS_CNT_ONE;
		end else begin
			sd_low_cnt_ff <= `AFS_CNT_ZERO;
		end
	end

	property p_sd_pulse_exact;
		@(posedge clk_i) disable iff (!resetn_i)
		$rose(sd_n_ff)
			|-> (sd_low_cnt_ff == `AFS_CNT_W'(`AFS_SD_PULSE_CYC));
	endproperty
	a_sd_pulse_exact: assert property (p_sd_pulse_exact)
		else $error("shutdown pulse length wrong");

	property p_both_low;
		@(posedge clk_i) disable iff (!resetn_i)
		(state_ff == AFS_RUN && cond_s.overtemp_err)
			|=> (!warn_n_ff && !sd_n_ff);
	endproperty
	a_both_low: assert property (p_both_low)
		else $error("overtemp error did not pull both lines");

	property p_oc_only;
		@(posedge clk_i) disable iff (!resetn_i)
		(state_ff == AFS_RUN && cond_s.overcurrent_err
			&& !cond_s.overtemp_err && !cond_s.overtemp_warn)
			|=> (warn_n_ff && !sd_n_ff);
	endproperty
	a_oc_only: assert property (p_oc_only)
		else $error("overcurrent code wrong");

	property p_no_retrigger;
		@(posedge clk_i) disable iff (!resetn_i)
		(state_ff == AFS_WAIT) |=> sd_n_ff;
	endproperty
	a_no_retrigger: assert property (p_no_retrigger)
		else $error("shutdown pulled while waiting for clear");

	property p_warn_release;
		@(posedge clk_i) disable iff (!resetn_i)
		(!cond_s.overtemp_warn && !cond_s.overtemp_err) |=> warn_n_ff;
	endproperty
	a_warn_release: assert property (p_warn_release)
		else $error("warning held without temperature cause");
endmodule
`default_nettype wire

// ### verif/afs_monitor.sv
// Controller-side model that resolves and watches the status lines
`timescale 1ns/10ps
`default_nettype none
module afs_monitor (
	// Clock and reset
	input  wire logic               clk_i,
	input  wire logic               resetn_i,
	// Status pins of the amplifier
	input  wire afs_pkg::afs_pins_t pins_i,
	// Synchronised pair, pulse length, event count
	output logic [1:0]              pair_o,
	output logic [7:0]              pulse_len_o,
	output logic [7:0]              n_events_o
);
	import afs_pkg::*;
	logic [1:0] line;
	logic [1:0] meta_ff;
	// Pull-ups: a released line reads high
	assign line[1] = pins_i.overtemp_warning_n_oe ?
		pins_i.overtemp_warning_n_o : 1'b1;
	assign line[0] = pins_i.shutdown_fault_n_oe ?
		pins_i.shutdown_fault_n_o : 1'b1;
	// Two-flop sync, pulse timing, latched event count
	always @(posedge clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			meta_ff <= 2'h3;
			pair_o <= 2'h3;
			pulse_len_o <= 8'h00;
			n_events_o <= 8'h00;
		end else begin
			meta_ff <= line;
			pair_o <= meta_ff;
			if (!meta_ff[0] && pair_o[0]) begin
				pulse_len_o <= 8'h00;
				n_events_o <= n_events_o + 8'h01;
			end else if (!pair_o[0]) begin
				pulse_len_o <= pulse_len_o + 8'h01;
			end
		end
	end
endmodule
`default_nettype wire

// ### verif/testbench.sv
// Self-checking bench for the fault status decoder
`timescale 1ns/10ps
`default_nettype none
`include "afs_regs.svh"
module testbench;
	import afs_pkg::*;
	logic       clk_i = 1'b0;
	logic       resetn_i = 1'b0;
	afs_cond_t  cond_i = '0;
	afs_pins_t  pins_o;
	logic       stage_run_o;
	logic [1:0] pair;
	logic [1:0] prev_pair = 2'h3;
	logic [7:0] pulse_len;
	logic [7:0] n_events;
	logic [1:0] exp_q[$];
	logic [31:0] rnd;
	logic [7:0] exp_pair;
	int         n_errors = 0;
	int         n_tests = 0;
	int         cycles = 0;
	int         seed = 32'he242a44e;
	always #12.5 clk_i = ~clk_i;
	afs_top i_dut (.clk_i(clk_i), .resetn_i(resetn_i), .cond_i(cond_i),
		.pins_o(pins_o), .stage_run_o(stage_run_o));
	afs_monitor i_mon (.clk_i(clk_i), .resetn_i(resetn_i), .pins_i(pins_o),
		.pair_o(pair), .pulse_len_o(pulse_len), .n_events_o(n_events));
	// Compare one value with its expectation
	task automatic check(input logic [7:0] seen, input logic [7:0] exp);
		n_tests++;
		if (seen !== exp) begin
			n_errors++;
			$display("unexpected at %0t: seen %0h expected %0h",
				$time, seen, exp);
		end
	endtask
	// Report counts and verdict
	task automatic tally_and_finish;
		$display("errors %0d, checks %0d", n_errors, n_tests);
		if (n_errors == 0 && n_tests > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask
	// Drive a condition, note up to two line pairs, then wait
	task automatic apply(input afs_cond_t c, input int n,
		input logic [1:0] e0, input logic [1:0] e1, input int w);
		@(negedge clk_i);
		cond_i = c;
		if (n > 0) exp_q.push_back(e0);
		if (n > 1) exp_q.push_back(e1);
		repeat (w) @(negedge clk_i);
	endtask
	// Watch the pair, pulse width and stage enable
	always @(negedge clk_i) begin
		cycles++;
		if (cycles > 3000) begin
			n_errors++;
			tally_and_finish();
		end else begin
			if (resetn_i && pair !== prev_pair) begin
				exp_pair = 8'hFF;
				if (exp_q.size() > 0)
					exp_pair = 8'(exp_q.pop_front());
				check(pair, exp_pair);
			end
			if (resetn_i && !prev_pair[0] && pair[0])
				check(pulse_len, 8'(`AFS_SD_PULSE_CYC));
			if (resetn_i && !pair[0])
				check(stage_run_o, 8'h00);
			prev_pair <= pair;
		end
	end
	// Main sequence
	initial begin
		repeat (8) @(negedge clk_i);
		check({pins_o.overtemp_warning_n_oe,
			pins_o.shutdown_fault_n_oe}, 8'h00);
		check(stage_run_o, 8'h01);
		resetn_i = 1'b1;
		apply(4'h1, 1, 2'h1, 2'h1, 20);
		apply(4'h0, 1, 2'h3, 2'h3, 20);
		apply(4'h4, 2, 2'h2, 2'h3, 80);
		apply(4'h0, 0, 2'h3, 2'h3, 20);
		apply(4'hC, 2, 2'h0, 2'h1, 80);
		apply(4'h0, 1, 2'h3, 2'h3, 20);
		apply(4'h8, 2, 2'h0, 2'h1, 80);
		apply(4'h0, 1, 2'h3, 2'h3, 20);
		apply(4'h2, 2, 2'h2, 2'h3, 80);
		apply(4'h0, 0, 2'h3, 2'h3, 20);
		apply(4'h4, 2, 2'h2, 2'h3, 90);
		apply(4'h5, 1, 2'h1, 2'h1, 20);
		apply(4'h4, 1, 2'h3, 2'h3, 20);
		apply(4'h0, 0, 2'h3, 2'h3, 20);
		apply(4'h4, 2, 2'h2, 2'h3, 80);
		apply(4'h0, 0, 2'h3, 2'h3, 20);
		for (int i = 0; i < 8; i++) begin
			rnd = $random(seed);
			apply({3'h0, rnd[0]}, int'(rnd[0] != cond_i.overtemp_warn),
				{~rnd[0], 1'b1}, 2'h3, 12);
		end
		repeat (10) @(negedge clk_i);
		check(n_events, 8'h06);
		check(8'(exp_q.size()), 8'h00);
		tally_and_finish();
	end
endmodule
`default_nettype wire
